// file: hdl/lpms_pkg.sv
// Constants and types for the low-power mode sequencer
// Function
// - Edge mode leaves deep halt only on a rising edge of halt pin
// - Edge mode enters deep halt even while halt pin is high
// - On release only oscillator restarts; warm-up keeps internal circuits idle
// - Two-bit warm-up selector; codes 00, 01, 10 valid, 11 reserved
// - Divider clock select at 1 doubles every warm-up length
// - After warm-up execution resumes at instruction after the halt request
// - Prescaler restarts from zero when execution resumes after warm-up
// - Reset pin low during deep halt resets at once, then normal state
// - Bit 4 of second control register enters sleep; CPU and watchdog stop
// - Memory, registers, status word and port latches hold during sleep
// - Program counter holds address two instructions past the sleep request
// - Master enable 0: enabled interrupt ends sleep, continue without handler
// - Master enable 1: enabled interrupt ends sleep by entering its handler
// - Reset pin low during sleep resets at once, then normal state
// - Watchdog interrupt just before sleep request: service it, skip sleep
// - Four reset causes: pin, address trap, watchdog, clock fault
// - Power-on does not initialise internal reset cause circuits; here por_n low clears cause_q
// - Warm-up lengths 3x2^16, 2^16, 2^14 fc cycles for codes 00, 01, 10
// - Bit 7 of first control register requests halt; clears on halt exit
package lpms_pkg;
    localparam logic [7:0] LPMS_ADDR_SYSCTL1 = 8'h38;
    localparam logic [7:0] LPMS_ADDR_SYSCTL2 = 8'h39;
    localparam logic [7:0] LPMS_ADDR_STATUS = 8'h3a;
    localparam logic [7:0] LPMS_ADDR_IRQ = 8'h3b;
    localparam logic [7:0] LPMS_ADDR_ENABLE = 8'h3c;
    localparam int LPMS_BIT_HALT = 7;
    localparam int LPMS_BIT_RELEASE = 6;
    localparam int LPMS_BIT_WARM_HI = 4;
    localparam int LPMS_BIT_WARM_LO = 3;
    localparam int LPMS_BIT_DIVSEL = 2;
    localparam int LPMS_BIT_SLEEP = 4;
    localparam logic [7:0] LPMS_SYSCTL1_RESET = 8'h00;
    localparam logic [7:0] LPMS_SYSCTL2_RESET = 8'h80;
    localparam logic [1:0] LPMS_WARM_LONG = 2'h0;
    localparam logic [1:0] LPMS_WARM_MID = 2'h1;
    localparam logic [1:0] LPMS_WARM_SHORT = 2'h2;
    localparam logic [18:0] LPMS_CYC_LONG = 19'h30000;
    localparam logic [18:0] LPMS_CYC_MID = 19'h10000;
    localparam logic [18:0] LPMS_CYC_SHORT = 19'h04000;
    localparam int LPMS_WCNT_W = 19;
    localparam int LPMS_PRE_W = 16;
    localparam logic [2:0] LPMS_PC_SKIP = 3'h2;
    localparam int LPMS_CAUSES = 4;
    localparam int LPMS_CAUSE_PIN = 0;
    localparam int LPMS_CAUSE_TRAP = 1;
    localparam int LPMS_CAUSE_WDOG = 2;
    localparam int LPMS_CAUSE_CLK = 3;
    typedef enum logic [3:0] {
        LPMS_RUN = 4'h1,
        LPMS_HALT = 4'h2,
        LPMS_WARM = 4'h4,
        LPMS_SLEEP = 4'h8
    } lpms_mode_e;
endpackage

// file: hdl/lpms_warm_if.sv
// Handshake between the sequencer and its warm-up timer
`timescale 1ns/1ns
interface lpms_warm_if;
    logic start;
    logic [18:0] length;
    logic done;
    modport ctl (output start, output length, input done);
    modport tmr (input start, input length, output done);
endinterface

// file: hdl/lpms_warm_timer.sv
// Warm-up interval counter
`timescale 1ns/1ns
module lpms_warm_timer import lpms_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    lpms_warm_if.tmr wi
);
    typedef struct packed {
        logic busy;
        logic [LPMS_WCNT_W-1:0] cnt;
        logic done;
    } lpms_tmr_s;
    lpms_tmr_s st, next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (wi.start) begin
            next_st.busy = 1'b1;
            next_st.cnt = wi.length - 19'h1;
        end else if (st.busy) begin
            // Counts on the restarted oscillator
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 19'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wi.done = st.done;
endmodule

// file: hdl/lpms_sequencer.sv
// Low-power mode sequencer top
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
module lpms_sequencer import lpms_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic por_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Pins and events
    input wire logic halt_pin_n,
    input wire logic [7:0] irq_request,
    input wire logic wdog_irq,
    input wire logic trap_event,
    input wire logic wdog_timeout,
    input wire logic clk_fault,
    input wire logic irq_master_enable,
    // CPU side
    input wire logic [15:0] pc_in,
    output logic cpu_clk_en,
    output logic wdog_run,
    output logic osc_enable,
    output logic [15:0] resume_pc,
    output logic vector_take,
    output logic resume_pulse,
    output logic soft_reset,
    output logic [LPMS_PRE_W-1:0] prescaler
);
    typedef struct packed {
        lpms_mode_e mode;
        logic [7:0] sysctl1;
        logic [7:0] sysctl2;
        logic [7:0] irq_pending_latch;
        logic [7:0] irq_individual_enable;
        logic [LPMS_CAUSES-1:0] cause;
        logic [1:0] halt_sync;
        logic halt_prev;
        logic wdog_seen;
        logic [15:0] resume_pc;
        logic cpu_clk_en;
        logic wdog_run;
        logic osc_enable;
        logic vector_take;
        logic resume_pulse;
        logic soft_reset;
        logic [LPMS_PRE_W-1:0] prescaler;
        logic [7:0] rdata;
    } lpms_top_s;
    lpms_top_s st, next_st;
    lpms_warm_if wi();
    logic [LPMS_CAUSES-1:0] cause_q;
    logic [1:0] pin_sync;
    logic [LPMS_CAUSES-1:0] cause_hit;

    function automatic logic [18:0] warm_len(input logic [1:0] code, input logic dbl);
        logic [18:0] base;
        base = LPMS_CYC_SHORT;
        case (code)
            LPMS_WARM_LONG: base = LPMS_CYC_LONG;
            LPMS_WARM_MID: base = LPMS_CYC_MID;
            LPMS_WARM_SHORT: base = LPMS_CYC_SHORT;
            default: base = LPMS_CYC_SHORT;
        endcase
        if (dbl) begin
            return {base[17:0], 1'b0};
        end
        return base;
    endfunction

    lpms_warm_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .wi(wi.tmr)
    );

    // Cause flags survive pin reset; pin level crosses through two flops
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            pin_sync <= 2'h3;
            cause_q <= '0;
        end else begin
            pin_sync <= {pin_sync[0], reset_n};
            if (wr && addr == LPMS_ADDR_STATUS) begin
                cause_q <= (cause_q & ~wdata[3:0]) | cause_hit;
            end else begin
                cause_q <= cause_q | cause_hit;
            end
        end
    end

    logic rise;
    logic irq_hit;
    always_comb begin
        rise = st.halt_sync[1] & ~st.halt_prev;
        irq_hit = |(st.irq_pending_latch & st.irq_individual_enable);
        cause_hit = {clk_fault, wdog_timeout, trap_event, !pin_sync[1]};
    end

    always_comb begin
        next_st = st;
        wi.start = 1'b0;
        wi.length = warm_len(st.sysctl1[LPMS_BIT_WARM_HI:LPMS_BIT_WARM_LO], st.sysctl1[LPMS_BIT_DIVSEL]);
        next_st.halt_sync = {st.halt_sync[0], halt_pin_n};
        next_st.halt_prev = st.halt_sync[1];
        next_st.vector_take = 1'b0;
        next_st.resume_pulse = 1'b0;
        // Internal causes pass on a reset request one cycle later, held while any cause stays high
        next_st.soft_reset = trap_event | wdog_timeout | clk_fault;
        next_st.rdata = 8'h00;
        next_st.wdog_seen = wdog_irq;
        next_st.irq_pending_latch = st.irq_pending_latch | irq_request;
        if (rd) begin
            case (addr)
                LPMS_ADDR_SYSCTL1: next_st.rdata = st.sysctl1;
                LPMS_ADDR_SYSCTL2: next_st.rdata = st.sysctl2;
                LPMS_ADDR_STATUS: next_st.rdata = {st.mode, cause_q};
                LPMS_ADDR_IRQ: next_st.rdata = st.irq_pending_latch;
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (wr) begin
            case (addr)
                LPMS_ADDR_SYSCTL1: next_st.sysctl1 = wdata;
                LPMS_ADDR_SYSCTL2: next_st.sysctl2 = wdata;
                // Load replaces latches with the written data; new requests win
                LPMS_ADDR_IRQ: next_st.irq_pending_latch = wdata | irq_request;
                LPMS_ADDR_ENABLE: next_st.irq_individual_enable = wdata;
                default: ;
            endcase
        end
        case (st.mode)
            LPMS_RUN: begin
                next_st.prescaler = st.prescaler + 16'h1;
                if (st.sysctl1[LPMS_BIT_HALT]) begin
                    // Entry regardless of pin level in edge mode
                    if (!st.sysctl1[LPMS_BIT_RELEASE]) begin
                        next_st.mode = LPMS_HALT;
                        next_st.cpu_clk_en = 1'b0;
                        next_st.wdog_run = 1'b0;
                        next_st.osc_enable = 1'b0;
                        next_st.prescaler = '0;
                        next_st.resume_pc = pc_in + 16'(LPMS_PC_SKIP);
                    end else begin
                        next_st.sysctl1[LPMS_BIT_HALT] = 1'b0;
                    end
                end else if (st.sysctl2[LPMS_BIT_SLEEP]) begin
                    if (st.wdog_seen || wdog_irq) begin
                        next_st.sysctl2[LPMS_BIT_SLEEP] = 1'b0;
                        next_st.vector_take = 1'b1;
                    end else begin
                        next_st.mode = LPMS_SLEEP;
                        next_st.cpu_clk_en = 1'b0;
                        next_st.wdog_run = 1'b0;
                        next_st.resume_pc = pc_in + 16'(LPMS_PC_SKIP);
                    end
                end
            end
            LPMS_HALT: begin
                if (rise) begin
                    next_st.mode = LPMS_WARM;
                    next_st.osc_enable = 1'b1;
                    wi.start = 1'b1;
                end
            end
            LPMS_WARM: begin
                if (wi.done) begin
                    next_st.mode = LPMS_RUN;
                    next_st.sysctl1[LPMS_BIT_HALT] = 1'b0;
                    next_st.cpu_clk_en = 1'b1;
                    next_st.wdog_run = 1'b1;
                    next_st.prescaler = '0;
                    next_st.resume_pulse = 1'b1;
                end
            end
            LPMS_SLEEP: begin
                next_st.prescaler = st.prescaler + 16'h1;
                if (irq_hit) begin
                    next_st.mode = LPMS_RUN;
                    next_st.sysctl2[LPMS_BIT_SLEEP] = 1'b0;
                    next_st.cpu_clk_en = 1'b1;
                    next_st.wdog_run = 1'b1;
                    next_st.resume_pulse = 1'b1;
                    next_st.vector_take = irq_master_enable;
                end
            end
            default: next_st.mode = LPMS_RUN;
        endcase
    end

    // Pin reset acts at once in any mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{mode: LPMS_RUN, sysctl1: LPMS_SYSCTL1_RESET, sysctl2: LPMS_SYSCTL2_RESET,
                    halt_sync: 2'h3, halt_prev: 1'b1, cpu_clk_en: 1'b1, wdog_run: 1'b1,
                    osc_enable: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        rdata = st.rdata;
        cpu_clk_en = st.cpu_clk_en;
        wdog_run = st.wdog_run;
        osc_enable = st.osc_enable;
        resume_pc = st.resume_pc;
        vector_take = st.vector_take;
        resume_pulse = st.resume_pulse;
        soft_reset = st.soft_reset;
        prescaler = st.prescaler;
    end

    property p_edge_only;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_HALT && !rise) |=> st.mode == LPMS_HALT;
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("halt left without edge");

    property p_idle_warm;
        @(posedge clk) disable iff (!reset_n)
        st.mode == LPMS_WARM |-> !cpu_clk_en && osc_enable;
    endproperty
    a_idle_warm: assert property (p_idle_warm) else $error("cpu ran in warm-up");

    property p_resume;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_WARM && wi.done) |=> cpu_clk_en && prescaler == '0 && !st.sysctl1[LPMS_BIT_HALT];
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume");

    property p_warm_len;
        @(posedge clk) disable iff (!reset_n)
        wi.start |-> ##1 (!wi.done) [*8];
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm-up too short");

    property p_sleep_stop;
        @(posedge clk) disable iff (!reset_n)
        st.mode == LPMS_SLEEP |-> !cpu_clk_en && !wdog_run;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("cpu ran in sleep");

    property p_wake;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_SLEEP && irq_hit) |=> resume_pulse && vector_take == $past(irq_master_enable);
    endproperty
    a_wake: assert property (p_wake) else $error("sleep wake wrong");

    property p_wdog_skip;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_RUN && !st.sysctl1[LPMS_BIT_HALT] && st.sysctl2[LPMS_BIT_SLEEP] && wdog_irq)
            |=> st.mode == LPMS_RUN && vector_take;
    endproperty
    a_wdog_skip: assert property (p_wdog_skip) else $error("slept over watchdog");

    property p_pc;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_RUN && next_st.mode == LPMS_SLEEP) |=> resume_pc == $past(pc_in) + 16'h2;
    endproperty
    a_pc: assert property (p_pc) else $error("resume address wrong");

    property p_soft_reset;
        @(posedge clk) disable iff (!reset_n)
        (trap_event || wdog_timeout || clk_fault) |=> soft_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("reset cause not passed on");

    property p_sleep_hold;
        @(posedge clk) disable iff (!reset_n)
        (st.mode == LPMS_SLEEP && !irq_hit) |=> st.mode == LPMS_SLEEP;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without interrupt");
endmodule

// file: tb/lpms_wake_src.sv
// Model of the halt pin driver and interrupt sources
`timescale 1ns/1ns
module lpms_wake_src #(parameter int HALF = 40) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bench commands
    input wire logic wake_run,
    input wire logic irq_go,
    input wire logic [7:0] irq_sel,
    input wire logic wdog_req,
    // Outputs to the sequencer
    output logic halt_pin_n,
    output logic [7:0] irq_request,
    output logic wdog_irq
);
    int cnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            halt_pin_n <= 1'b1;
            irq_request <= 8'h00;
            wdog_irq <= 1'b0;
        end else begin
            irq_request <= irq_go ? irq_sel : 8'h00;
            wdog_irq <= wdog_req;
            // Fixed-period wake signal; rests high when stopped
            if (!wake_run) begin
                cnt <= 0;
                halt_pin_n <= 1'b1;
            end else if (cnt == HALF - 1) begin
                cnt <= 0;
                halt_pin_n <= !halt_pin_n;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// file: tb/low_power_mode_sequencer_test.sv
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ns
module low_power_mode_sequencer_test import lpms_pkg::*;;
    localparam int HALF = 40;
    logic clk = 0, reset_n = 0, por_n = 0, wr = 0, rd = 0, irq_master_enable = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, irq_request, irq_sel = 8'h00, v;
    logic halt_pin_n, wdog_irq, trap_event = 0, wdog_timeout = 0, clk_fault = 0;
    logic wake_run = 0, irq_go = 0, wdog_req = 0;
    logic [15:0] pc_in = 16'h1230, resume_pc, prescaler;
    logic cpu_clk_en, wdog_run, osc_enable, vector_take, resume_pulse, soft_reset;
    int num_errors = 0, compares = 0, n_res = 0, n_vec = 0, r0, r1;
    lpms_sequencer dut (.clk(clk), .reset_n(reset_n), .por_n(por_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .halt_pin_n(halt_pin_n), .irq_request(irq_request), .wdog_irq(wdog_irq),
        .trap_event(trap_event), .wdog_timeout(wdog_timeout), .clk_fault(clk_fault),
        .irq_master_enable(irq_master_enable), .pc_in(pc_in), .cpu_clk_en(cpu_clk_en), .wdog_run(wdog_run),
        .osc_enable(osc_enable), .resume_pc(resume_pc), .vector_take(vector_take),
        .resume_pulse(resume_pulse), .soft_reset(soft_reset), .prescaler(prescaler));
    lpms_wake_src #(.HALF(HALF)) src (.clk(clk), .reset_n(reset_n), .wake_run(wake_run), .irq_go(irq_go),
        .irq_sel(irq_sel), .wdog_req(wdog_req), .halt_pin_n(halt_pin_n), .irq_request(irq_request),
        .wdog_irq(wdog_irq));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (resume_pulse === 1'b1) n_res <= n_res + 1;
        if (vector_take === 1'b1) n_vec <= n_vec + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        d = rdata;
        tick(1);
    endtask
    task automatic end_sim();
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic halt_cycle(input logic [7:0] ctl, input int len);
        int n;
        wr_reg(LPMS_ADDR_SYSCTL1, ctl);
        tick(20);
        chk("halt_cpu", cpu_clk_en, 1'b0);
        chk("halt_osc", osc_enable, 1'b0);
        wake_run <= 1'b1;
        tick(HALF + 10);
        chk("halt_pin_low", cpu_clk_en | osc_enable, 1'b0);
        n = 0;
        while (osc_enable !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        wake_run <= 1'b0;
        r0 = n_res;
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 70000) begin
            tick(1);
            n++;
        end
        chk("warm_len", n >= len && n <= len + 4, 1'b1);
        chk("prescaler", prescaler, 16'h0000);
        tick(1);
        chk("resume", n_res - r0, 1);
        chk("resume_pc", resume_pc, 16'h1232);
        rd_reg(LPMS_ADDR_SYSCTL1, v);
        chk("halt_bit", v[LPMS_BIT_HALT], 1'b0);
    endtask
    task automatic sleep_wake(input logic ime);
        r0 = n_res;
        r1 = n_vec;
        irq_master_enable <= ime;
        wr_reg(LPMS_ADDR_SYSCTL2, 8'h90);
        pc_in <= 16'h5555;
        tick(5);
        chk("sleep_cpu", {cpu_clk_en, wdog_run, osc_enable}, 3'h1);
        chk("sleep_pc", resume_pc, 16'h1232);
        irq_sel <= 8'h01;
        irq_go <= 1'b1;
        tick(1);
        irq_go <= 1'b0;
        pc_in <= 16'h1230;
        tick(8);
        chk("wake_cpu", cpu_clk_en, 1'b1);
        chk("wake_resume", n_res - r0, 1);
        chk("wake_vector", n_vec - r1, ime);
        wr_reg(LPMS_ADDR_IRQ, 8'h00);
        rd_reg(LPMS_ADDR_IRQ, v);
        chk("latch_clear", v, 8'h00);
    endtask
    initial begin
        #280000;
        num_errors++;
        end_sim();
    end
    initial begin
        tick(2);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        tick(1);
        rd_reg(LPMS_ADDR_SYSCTL1, v);
        chk("ctl1_reset", v, LPMS_SYSCTL1_RESET);
        rd_reg(LPMS_ADDR_SYSCTL2, v);
        chk("ctl2_reset", v, LPMS_SYSCTL2_RESET);
        rd_reg(8'h50, v);
        chk("unmapped", v, 8'h00);
        rd_reg(LPMS_ADDR_ENABLE, v);
        chk("enable_wo", v, 8'h00);
        $display("Test registers done");
        halt_cycle(8'h90, 32'(LPMS_CYC_SHORT));
        halt_cycle(8'h94, 2 * 32'(LPMS_CYC_SHORT));
        wr_reg(LPMS_ADDR_SYSCTL1, 8'hd0);
        tick(3);
        chk("level_cancel", cpu_clk_en, 1'b1);
        rd_reg(LPMS_ADDR_SYSCTL1, v);
        chk("level_bit", v[LPMS_BIT_HALT], 1'b0);
        $display("Test deep halt done");
        wr_reg(LPMS_ADDR_ENABLE, 8'h01);
        sleep_wake(1'b0);
        sleep_wake(1'b1);
        r1 = n_vec;
        wdog_req <= 1'b1;
        tick(3);
        wr_reg(LPMS_ADDR_SYSCTL2, 8'h90);
        tick(5);
        wdog_req <= 1'b0;
        tick(3);
        chk("wdog_no_sleep", cpu_clk_en, 1'b1);
        chk("wdog_vector", n_vec - r1, 1);
        $display("Test sleep done");
        for (int i = 0; i < 2; i++) begin
            wr_reg(i ? LPMS_ADDR_SYSCTL1 : LPMS_ADDR_SYSCTL2, 8'h90);
            tick(5);
            chk("pre_reset", cpu_clk_en, 1'b0);
            reset_n <= 1'b0;
            tick(1);
            chk("reset_cpu", {cpu_clk_en, wdog_run, osc_enable}, 3'h7);
            reset_n <= 1'b1;
            tick(1);
            rd_reg(LPMS_ADDR_STATUS, v);
            chk("reset_mode", v[7:4], LPMS_RUN);
        end
        rd_reg(LPMS_ADDR_STATUS, v);
        chk("cause_pin", v[LPMS_CAUSE_PIN], 1'b1);
        wr_reg(LPMS_ADDR_STATUS, 8'h01);
        rd_reg(LPMS_ADDR_STATUS, v);
        chk("cause_pin_clear", v[LPMS_CAUSE_PIN], 1'b0);
        for (int i = 1; i < LPMS_CAUSES; i++) begin
            {clk_fault, wdog_timeout, trap_event} <= 3'(1 << (i - 1));
            tick(1);
            chk("soft_reset", soft_reset, 1'b1);
            {clk_fault, wdog_timeout, trap_event} <= 3'h0;
            tick(2);
            chk("soft_reset_end", soft_reset, 1'b0);
            reset_n <= 1'b0;
            tick(1);
            reset_n <= 1'b1;
            tick(1);
            rd_reg(LPMS_ADDR_STATUS, v);
            chk("cause_set", v[i], 1'b1);
            wr_reg(LPMS_ADDR_STATUS, 8'(1 << i));
            rd_reg(LPMS_ADDR_STATUS, v);
            chk("cause_clear", v[i], 1'b0);
        end
        $display("Test reset done");
        end_sim();
    end
endmodule
